// file: src/spc_pkg.sv
/*
 * Constants for the serial pin, status and control block of a clock multiplier.
 * Assumes one 200 MHz core clock; pins reach the block unsynchronised.
 */
// Function
// - In I2C mode the shared address/data-out pin is an input giving address bit 1.
// - In four-wire SPI mode the shared address/data-out pin drives read data to the host.
// - In I2C mode the shared select pin is sampled as strapped address bit 0.
// - In SPI mode the shared select pin is an active-low chip select that frames transfers.
// - The interrupt output goes low whenever internal device status has changed.
// - Holding the reset pin low returns the SPI port, configuration, status and pin drivers to their initial state.
// - Reset loads every configuration register with its default value.
// - Clock outputs stay disabled while reset is in effect.
// - The output-disable pin held high disables every clock output.
// - The lock indicator is high while the main PLL is locked and low otherwise.
// - Each input clock indicator is low while loss of clock is seen on that input.
// - The data pin is two-way in I2C and three-wire SPI, input only in four-wire SPI; this block never drives it in I2C mode.
package spc_pkg;
    // pin slots in the synchroniser vector
    localparam int PIN_RESET_N  = 0;
    localparam int PIN_I2C_SEL  = 1;
    localparam int PIN_SCLK     = 2;
    localparam int PIN_SEL_N    = 3;
    localparam int PIN_ADDR1    = 4;
    localparam int PIN_DATA     = 5;
    localparam int PIN_OUT_DIS  = 6;
    localparam int PIN_COUNT    = 7;
    // idle levels follow the pin pulls: reset, strap and select pulled up
    localparam logic [6:0] PIN_INIT = 7'h0B;

    // spi frame: rw bit, 7-bit address, 8-bit data, msb first
    localparam int          FRAME_BITS  = 16;
    localparam int          HDR_BITS    = 8;
    localparam logic [6:0]  ADDR_STATUS = 7'h00;
    localparam logic [6:0]  ADDR_CONFIG = 7'h01;

    // status register fields
    localparam int STS_LOS_LSB   = 0;   // four sticky loss-of-clock changes
    localparam int STS_LOCK_CHG  = 4;   // sticky lock change
    localparam int STS_LOCK_LIVE = 5;   // live lock level, read only
    localparam int STS_STICKY_W  = 5;

    // config register fields and default
    localparam int         CFG_OUT_ON  = 0;
    localparam logic [7:0] CFG_DEFAULT = 8'h01;
endpackage : spc_pkg

// file: src/spc_top.sv
/*
 * Serial pin muxing, a small SPI register port, interrupt, reset, output
 * disable and lock / loss-of-clock indicators.
 * Assumes i_pll_locked and i_input_clock_lost come from logic on i_clock;
 * all pins are asynchronous and the bench resolves the two-way pins.
 */
`timescale 1ns/100ps
module spc_top (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_hard_reset_n,
    input  wire logic       i_i2c_select,
    input  wire logic       i_serial_clock,
    input  wire logic       i_addr0_or_select_n,
    input  wire logic       i_addr1_or_serial_out,
    input  wire logic       i_serial_data,
    input  wire logic       i_outputs_disable,
    input  wire logic       i_spi_three_wire,
    input  wire logic       i_pll_locked,
    input  wire logic [3:0] i_input_clock_lost,
    output logic            o_addr1_or_serial_out,
    output logic            o_addr1_or_serial_out_oe,
    output logic            o_serial_data,
    output logic            o_serial_data_oe,
    output logic            o_i2c_mode,
    output logic [1:0]      o_i2c_address,
    output logic            o_status_irq_n,
    output logic            o_clock_outputs_enable,
    output logic            o_lock_lost_n,
    output logic            o_input0_clock_missing_n,
    output logic            o_input1_clock_missing_n,
    output logic            o_input2_clock_missing_n,
    output logic            o_input3_clock_missing_n
);
    localparam int PC = spc_pkg::PIN_COUNT;

    // a change counts only once the second and third stages agree
    function automatic logic [PC-1:0] spc_filter(input logic [PC-1:0] s2,
                                                 input logic [PC-1:0] s3,
                                                 input logic [PC-1:0] held);
        spc_filter = ((s2 ^ s3) & held) | (~(s2 ^ s3) & s2);
    endfunction : spc_filter

    logic [PC-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
    logic [PC-1:0] pin_raw;
    logic          sclk_prev_q;
    logic          hold;
    logic          i2c_mode;
    logic          cs_active;
    logic          sclk_rise;
    logic          sclk_fall;
    logic [4:0]    bit_cnt_q;
    logic [14:0]   shift_q;
    logic [7:0]    hdr;
    logic          read_q;
    logic [6:0]    addr_q;
    logic [7:0]    tx_q;
    logic [7:0]    config_q;
    logic [spc_pkg::STS_STICKY_W-1:0] sticky_q;
    logic [spc_pkg::STS_STICKY_W-1:0] events;
    logic [spc_pkg::STS_STICKY_W-1:0] clear_mask;
    logic          lock_prev_q;
    logic [3:0]    lost_prev_q;
    logic          frame_end;
    logic [7:0]    status_view;

    assign pin_raw = {i_outputs_disable, i_serial_data, i_addr1_or_serial_out,
                      i_addr0_or_select_n, i_serial_clock, i_i2c_select, i_hard_reset_n};

    // three-stage synchronisers; only the second and third stages are looked at
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pin_s1_q <= spc_pkg::PIN_INIT;
            pin_s2_q <= spc_pkg::PIN_INIT;
            pin_s3_q <= spc_pkg::PIN_INIT;
            pin_f_q  <= spc_pkg::PIN_INIT;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q  <= spc_filter(pin_s2_q, pin_s3_q, pin_f_q);
        end
    end

    // reset pin low holds spi framing, config, sticky bits and pin drivers below at their initial state
    assign hold      = ~pin_f_q[spc_pkg::PIN_RESET_N];
    assign i2c_mode  = pin_f_q[spc_pkg::PIN_I2C_SEL];
    assign cs_active = ~i2c_mode & ~pin_f_q[spc_pkg::PIN_SEL_N];
    assign sclk_rise = pin_f_q[spc_pkg::PIN_SCLK] & ~sclk_prev_q;
    assign sclk_fall = ~pin_f_q[spc_pkg::PIN_SCLK] & sclk_prev_q;
    assign hdr       = {shift_q[6:0], pin_f_q[spc_pkg::PIN_DATA]};
    assign frame_end = cs_active & sclk_rise
                       & (bit_cnt_q == 5'(spc_pkg::FRAME_BITS - 1));

    // serial clock edge finder, runs from the filtered pin
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= pin_f_q[spc_pkg::PIN_SCLK];
        end
    end

    // spi framing: bit counter and input shifter, cleared whenever select is high
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            bit_cnt_q <= 5'h00;
            shift_q   <= 15'h0000;
        end else if (hold || !cs_active) begin
            bit_cnt_q <= 5'h00;
            shift_q   <= 15'h0000;
        end else if (sclk_rise) begin
            shift_q   <= {shift_q[13:0], pin_f_q[spc_pkg::PIN_DATA]};
            if (bit_cnt_q != 5'(spc_pkg::FRAME_BITS))
                bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // header capture and read-data shifter, data changes on the falling edge
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            read_q <= 1'b0;
            addr_q <= 7'h00;
            tx_q   <= 8'h00;
        end else if (hold || !cs_active) begin
            read_q <= 1'b0;
            addr_q <= 7'h00;
            tx_q   <= 8'h00;
        end else if (sclk_rise && bit_cnt_q == 5'(spc_pkg::HDR_BITS - 1)) begin
            read_q <= hdr[7];
            addr_q <= hdr[6:0];
            if (hdr[6:0] == spc_pkg::ADDR_STATUS)
                tx_q <= status_view;
            else if (hdr[6:0] == spc_pkg::ADDR_CONFIG)
                tx_q <= config_q;
            else
                tx_q <= 8'h00;                  // unmapped address reads zero
        end else if (sclk_fall && bit_cnt_q > 5'(spc_pkg::HDR_BITS)) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    assign status_view = {2'b00, lock_prev_q, sticky_q};

    // configuration register, written at the end of a write frame
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            config_q <= spc_pkg::CFG_DEFAULT;
        end else if (hold) begin
            config_q <= spc_pkg::CFG_DEFAULT;
        end else if (frame_end && !read_q && addr_q == spc_pkg::ADDR_CONFIG) begin
            config_q <= hdr;
        end
    end

    // status change detection on lock and the four loss-of-clock levels
    assign events     = {i_pll_locked ^ lock_prev_q, i_input_clock_lost ^ lost_prev_q};
    assign clear_mask = (frame_end && !read_q && addr_q == spc_pkg::ADDR_STATUS)
                        ? hdr[spc_pkg::STS_STICKY_W-1:0] : '0;

    // sticky bits: write one to clear, a new event in the same cycle wins
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            lock_prev_q <= 1'b0;
            lost_prev_q <= 4'h0;
            sticky_q    <= '0;
        end else if (hold) begin
            lock_prev_q <= i_pll_locked;
            lost_prev_q <= i_input_clock_lost;
            sticky_q    <= '0;
        end else begin
            lock_prev_q <= i_pll_locked;
            lost_prev_q <= i_input_clock_lost;
            sticky_q    <= (sticky_q & ~clear_mask) | events;
        end
    end

    // pin drivers; 4-wire read data rides the address pin, 3-wire rides the data pin
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_addr1_or_serial_out    <= 1'b0;
            o_addr1_or_serial_out_oe <= 1'b0;
            o_serial_data            <= 1'b0;
            o_serial_data_oe         <= 1'b0;
        end else if (hold) begin
            o_addr1_or_serial_out    <= 1'b0;
            o_addr1_or_serial_out_oe <= 1'b0;
            o_serial_data            <= 1'b0;
            o_serial_data_oe         <= 1'b0;
        end else begin
            // in i2c mode the pin stays released and is only read
            o_addr1_or_serial_out    <= tx_q[7];
            o_addr1_or_serial_out_oe <= cs_active & ~i_spi_three_wire;
            o_serial_data            <= tx_q[7];
            // never driven in 4-wire mode; the i2c engine is outside this block
            o_serial_data_oe         <= cs_active & i_spi_three_wire & read_q
                                        & (bit_cnt_q >= 5'(spc_pkg::HDR_BITS));
        end
    end

    // strap address is taken from filtered pins, never at the asynchronous reset
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_i2c_mode    <= 1'b1;
            o_i2c_address <= 2'h0;
        end else begin
            o_i2c_mode    <= i2c_mode;
            if (i2c_mode)
                o_i2c_address <= {pin_f_q[spc_pkg::PIN_ADDR1],
                                  pin_f_q[spc_pkg::PIN_SEL_N]};
        end
    end

    // status and output-enable indicators
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_status_irq_n           <= 1'b1;
            o_clock_outputs_enable   <= 1'b0;
            o_lock_lost_n            <= 1'b0;
            o_input0_clock_missing_n <= 1'b0;
            o_input1_clock_missing_n <= 1'b0;
            o_input2_clock_missing_n <= 1'b0;
            o_input3_clock_missing_n <= 1'b0;
        end else begin
            o_status_irq_n           <= ~(|sticky_q);
            o_clock_outputs_enable   <= ~hold
                                        & ~pin_f_q[spc_pkg::PIN_OUT_DIS]
                                        & config_q[spc_pkg::CFG_OUT_ON];
            o_lock_lost_n            <= i_pll_locked;
            o_input0_clock_missing_n <= ~i_input_clock_lost[0];
            o_input1_clock_missing_n <= ~i_input_clock_lost[1];
            o_input2_clock_missing_n <= ~i_input_clock_lost[2];
            o_input3_clock_missing_n <= ~i_input_clock_lost[3];
        end
    end
endmodule : spc_top

// file: verification/spc_properties.sv
/*
 * Concurrent checks on the ports of spc_top.
 * Assumes the bench moves pins away from the rising clock edge.
 */
`timescale 1ns/100ps
module spc_checker (
    input wire logic       i_clock,
    input wire logic       i_rst,
    input wire logic       i_hard_reset_n,
    input wire logic       i_i2c_select,
    input wire logic       i_addr0_or_select_n,
    input wire logic       i_addr1_or_serial_out,
    input wire logic       i_outputs_disable,
    input wire logic       i_spi_three_wire,
    input wire logic       i_pll_locked,
    input wire logic [3:0] i_input_clock_lost,
    input wire logic       o_addr1_or_serial_out_oe,
    input wire logic       o_serial_data_oe,
    input wire logic       o_i2c_mode,
    input wire logic [1:0] o_i2c_address,
    input wire logic       o_status_irq_n,
    input wire logic       o_clock_outputs_enable,
    input wire logic       o_lock_lost_n,
    input wire logic       o_input0_clock_missing_n,
    input wire logic       o_input1_clock_missing_n,
    input wire logic       o_input2_clock_missing_n,
    input wire logic       o_input3_clock_missing_n
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // indicators trail their levels by one register; skip the edge after reset
    a_lock_follow: assert property (!$past(i_rst) |-> o_lock_lost_n == $past(i_pll_locked))
        else $error("lock indicator wrong");
    a_loss_follow: assert property (!$past(i_rst) |-> {o_input3_clock_missing_n,
        o_input2_clock_missing_n, o_input1_clock_missing_n, o_input0_clock_missing_n}
        == ~$past(i_input_clock_lost)) else $error("loss indicator wrong");
    a_irq_on_change: assert property (!$past(i_rst) && i_hard_reset_n &&
        $past(i_hard_reset_n, 6) && ($changed(i_pll_locked) || $changed(i_input_clock_lost))
        |-> ##[1:3] !o_status_irq_n) else $error("no interrupt after status change");
    // in i2c mode only a reset can clear the pending status
    a_irq_stays: assert property (!o_status_irq_n && o_i2c_mode && i_hard_reset_n &&
        $past(i_hard_reset_n, 6) |=> !o_status_irq_n) else $error("interrupt dropped");
    a_reset_off: assert property ((!i_hard_reset_n)[*6] |-> !o_clock_outputs_enable)
        else $error("outputs on during reset");
    a_disable_pin: assert property (i_outputs_disable[*6] |-> !o_clock_outputs_enable)
        else $error("outputs on while disabled");
    a_reset_default: assert property ($rose(i_hard_reset_n) ##0
        (i_hard_reset_n && !i_outputs_disable)[*8] |-> o_clock_outputs_enable)
        else $error("config not back to default");
    a_select_frames: assert property (i_addr0_or_select_n[*8]
        |-> !o_addr1_or_serial_out_oe && !o_serial_data_oe) else $error("drive without select");
    a_i2c_no_drive: assert property (o_i2c_mode
        |-> !o_addr1_or_serial_out_oe && !o_serial_data_oe) else $error("drive in i2c mode");
    a_four_wire_in: assert property ((!i_spi_three_wire)[*8] |-> !o_serial_data_oe)
        else $error("data pin driven in four-wire mode");
    a_strap_address: assert property ((i_i2c_select &&
        $stable({i_addr1_or_serial_out, i_addr0_or_select_n}))[*7]
        |-> o_i2c_address == {i_addr1_or_serial_out, i_addr0_or_select_n})
        else $error("strapped address wrong");
endmodule : spc_checker

bind spc_top spc_checker u_checker (.i_clock(i_clock), .i_rst(i_rst),
    .i_hard_reset_n(i_hard_reset_n), .i_i2c_select(i_i2c_select),
    .i_addr0_or_select_n(i_addr0_or_select_n), .i_addr1_or_serial_out(i_addr1_or_serial_out),
    .i_outputs_disable(i_outputs_disable), .i_spi_three_wire(i_spi_three_wire),
    .i_pll_locked(i_pll_locked), .i_input_clock_lost(i_input_clock_lost),
    .o_addr1_or_serial_out_oe(o_addr1_or_serial_out_oe), .o_serial_data_oe(o_serial_data_oe),
    .o_i2c_mode(o_i2c_mode), .o_i2c_address(o_i2c_address), .o_status_irq_n(o_status_irq_n),
    .o_clock_outputs_enable(o_clock_outputs_enable), .o_lock_lost_n(o_lock_lost_n),
    .o_input0_clock_missing_n(o_input0_clock_missing_n),
    .o_input1_clock_missing_n(o_input1_clock_missing_n),
    .o_input2_clock_missing_n(o_input2_clock_missing_n),
    .o_input3_clock_missing_n(o_input3_clock_missing_n));

// file: verification/spc_host_model.sv
/*
 * Host side SPI master: mode 0, msb first, 16-bit frames, 160 ns serial clock.
 * Assumes its signals are sampled by the 200 MHz core clock given on i_clock.
 */
`timescale 1ns/100ps
module spc_host_model (
    input  wire logic       i_clock,
    input  wire logic       i_read_line,
    output logic            o_serial_clock,
    output logic            o_select_n,
    output logic            o_write_line,
    output logic            o_done,
    output logic [7:0]      o_read_byte
);
    // serial clock stands low outside frames; read bits taken on the rising edge
    task automatic frame(input logic [15:0] tx);
        o_select_n = 1'b0;
        repeat (8) @(negedge i_clock);
        for (int i = 15; i >= 0; i--) begin
            o_write_line = tx[i];
            repeat (16) @(negedge i_clock);
            o_serial_clock = 1'b1;
            if (i < 8) o_read_byte[i] = i_read_line;
            repeat (16) @(negedge i_clock);
            o_serial_clock = 1'b0;
        end
        repeat (8) @(negedge i_clock);
        o_select_n = 1'b1;
        o_write_line = ~o_write_line; // released line shows no stale bit
        o_done = tx[15];
        @(negedge i_clock);
        o_done = 1'b0;
        repeat (8) @(negedge i_clock);
    endtask : frame
    initial begin
        o_serial_clock = 1'b0;
        o_select_n = 1'b1;
        o_write_line = 1'b0;
        o_done = 1'b0;
        o_read_byte = 8'h00;
    end
endmodule : spc_host_model

// file: verification/testbench.sv
/*
 * Self-checking bench for spc_top with a host model on the serial pins.
 * Assumes the design resolves nothing itself: two-way pins are merged here.
 */
`timescale 1ns/100ps
module testbench;
    logic clk = 0, rst = 1, hrst_n = 1, strap = 1, a0 = 1, a1 = 0, dis = 0, three = 0;
    logic locked = 1, sdo, sdo_oe, sd, sd_oe, mode, irq_n, out_en, lol_n, sclk, hsel, hwr, done;
    logic [3:0] lost = 4'h0, miss_n;
    logic [1:0] addr;
    logic [4:0] flip;
    logic [7:0] rd_byte, expq[$];
    int err_total = 0, compares = 0, seed = 62;
    // merged levels of the shared pins
    wire a1_pin = sdo_oe ? sdo : a1;
    wire sd_pin = sd_oe ? sd : hwr;
    wire rd_line = three ? sd_pin : a1_pin;
    spc_top DUT (.i_clock(clk), .i_rst(rst), .i_hard_reset_n(hrst_n), .i_i2c_select(strap),
        .i_serial_clock(sclk), .i_addr0_or_select_n(hsel & a0), .i_addr1_or_serial_out(a1_pin),
        .i_serial_data(sd_pin), .i_outputs_disable(dis), .i_spi_three_wire(three),
        .i_pll_locked(locked), .i_input_clock_lost(lost), .o_addr1_or_serial_out(sdo),
        .o_addr1_or_serial_out_oe(sdo_oe), .o_serial_data(sd), .o_serial_data_oe(sd_oe),
        .o_i2c_mode(mode), .o_i2c_address(addr), .o_status_irq_n(irq_n),
        .o_clock_outputs_enable(out_en), .o_lock_lost_n(lol_n),
        .o_input0_clock_missing_n(miss_n[0]), .o_input1_clock_missing_n(miss_n[1]),
        .o_input2_clock_missing_n(miss_n[2]), .o_input3_clock_missing_n(miss_n[3]));
    spc_host_model host (.i_clock(clk), .i_read_line(rd_line), .o_serial_clock(sclk),
        .o_select_n(hsel), .o_write_line(hwr), .o_done(done), .o_read_byte(rd_byte));
    always #2.5 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic finish_test;
        if (err_total == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    // reads note their expected byte before the frame goes out
    task automatic spi(input logic rw, input logic [6:0] ad, input logic [7:0] d);
        if (rw) expq.push_back(d);
        host.frame({rw, ad, rw ? 8'h00 : d});
    endtask : spi
    // each finished read is compared with the oldest note
    always @(posedge done) check(rd_byte, expq.pop_front());
    // watchdog sized well above the 14 frames of the run
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (12) @(negedge clk);
        check({7'h00, out_en}, 8'h00);
        rst = 0;
        a1 = 1'($random(seed));
        a0 = 1'($random(seed));
        repeat (10) @(negedge clk);
        check({6'h00, addr}, {6'h00, a1, a0});
        check({7'h00, sdo_oe | sd_oe}, 8'h00);
        strap = 0;
        a0 = 1;
        repeat (10) @(negedge clk);
        spi(1, spc_pkg::ADDR_CONFIG, spc_pkg::CFG_DEFAULT);
        spi(0, spc_pkg::ADDR_STATUS, 8'h1F);
        // random status changes, alternating four-wire and three-wire reads
        for (int k = 0; k < 4; k++) begin
            three = k[0];
            flip = 5'($random(seed)) | 5'h01;
            {locked, lost} = {locked, lost} ^ flip;
            repeat (4) @(negedge clk);
            check({3'h0, lol_n, miss_n}, {3'h0, locked, ~lost});
            check({7'h00, irq_n}, 8'h00);
            spi(1, spc_pkg::ADDR_STATUS, {2'b00, locked, flip});
            spi(0, spc_pkg::ADDR_STATUS, 8'h1F);
            check({7'h00, irq_n}, 8'h01);
        end
        spi(1, 7'h05, 8'h00);
        dis = 1;
        repeat (8) @(negedge clk);
        check({7'h00, out_en}, 8'h00);
        dis = 0;
        repeat (8) @(negedge clk);
        check({7'h00, out_en}, 8'h01);
        // config bit0 gates the outputs; then a non-default value that reset must undo
        spi(0, spc_pkg::ADDR_CONFIG, 8'h00);
        check({7'h00, out_en}, 8'h00);
        spi(0, spc_pkg::ADDR_CONFIG, 8'h03);
        check({7'h00, out_en}, 8'h01);
        hrst_n = 0;
        repeat (8) @(negedge clk);
        check({7'h00, out_en}, 8'h00);
        hrst_n = 1;
        repeat (10) @(negedge clk);
        check({7'h00, out_en}, 8'h01);
        spi(1, spc_pkg::ADDR_CONFIG, spc_pkg::CFG_DEFAULT);
        check(8'(expq.size()), 8'h00);
        finish_test();
    end
endmodule : testbench
